// >>> dv/interrupt_vector_address_lookup_tb.sv
// self-checking bench for the interrupt vector address lookup
`timescale 1ns/1ps
`include "ivl_cfg.svh"
module interrupt_vector_address_lookup_tb
   import ivl_pkg::*;
;
   logic        clock;
   logic        sys_rst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        accept_valid;
   logic [3:0]  accept_source;
   logic [5:0]  accept_swi;
   logic        accept_ready;
   logic [17:0] periph_req;
   logic        mem_rd;
   logic [23:0] mem_addr;
   logic [7:0]  mem_rdata;
   logic        vec_valid;
   logic [23:0] vec_addr;
   logic [5:0]  vec_swi;
   logic        bkpt_table;
   logic [23:0] base;
   logic [23:0] emu;
   logic [5:0]  swi;
   int          n;
   int          seed;
   int          failures;
   int          checked;
   logic [23:0] fixed_vec [7] = '{`VEC_UNDEF, `VEC_OVF, `VEC_BKPT, `VEC_AMATCH,
                                  `VEC_WDT, `VEC_NMI, `VEC_RST};

   // ==========================================================
   // clock, design and partner
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   interrupt_vector_address_lookup u_dut (.clock(clock), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .accept_valid(accept_valid), .accept_source(accept_source),
      .accept_swi(accept_swi), .accept_ready(accept_ready), .periph_req(periph_req),
      .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
      .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_swi(vec_swi));

   vector_memory_model u_mem (.clock(clock), .sys_rst(sys_rst), .bkpt_table(bkpt_table),
      .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

   // ==========================================================
   // reference model: memory image and vector assembly, low byte first
   function automatic logic [7:0] mem_byte(input logic [23:0] a);
      mem_byte = (bkpt_table && a == 24'hFFFFE7) ? 8'hFF : a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction

   function automatic logic [23:0] vec_of(input logic [23:0] a);
      vec_of = {mem_byte(a + 24'h2), mem_byte(a + 24'h1), mem_byte(a)};
   endfunction

   // ==========================================================
   // compare and closing
   task automatic check_val(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ==========================================================
   // register port master
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      check_val("register data", exp, reg_rdata);
   endtask

   // ==========================================================
   // vector side: bounded wait, sequencer offer, peripheral pulse
   // sampled mid-cycle, while the one-cycle vector pulse stands
   task automatic wait_vec(input int limit, output int cnt);
      cnt = 0;
      for (int i = 1; i <= limit && cnt == 0; i++) begin
         @(negedge clock);
         if (vec_valid === 1'b1) cnt = i;
      end
   endtask

   // lat 0 means the offer must be swallowed without a vector
   task automatic take(input logic [3:0] src, input logic [5:0] num,
                       input logic [23:0] exp, input int lat);
      @(posedge clock);
      accept_valid  <= 1'b1;
      accept_source <= src;
      accept_swi    <= num;
      @(posedge clock);
      accept_valid <= 1'b0;
      wait_vec(20, n);
      check_val("latency", 32'(lat), 32'(n));
      if (lat != 0 && n == 0) end_of_test();
      if (lat != 0) begin
         check_val("vector address", {8'h00, exp}, {8'h00, vec_addr});
         check_val("vector number", 32'h0, {26'h0, vec_swi});
      end
   endtask

   task automatic serve(input int k);
      wait_vec(40, n);
      if (n == 0) begin
         failures++;
         end_of_test();
      end
      check_val("vector address", {8'h00, vec_of(base + 24'(4 * (8 + k)))},
                {8'h00, vec_addr});
      check_val("vector number", 32'(8 + k), {26'h0, vec_swi});
   endtask

   task automatic pulse(input logic [17:0] bits);
      @(posedge clock);
      periph_req <= bits;
      @(posedge clock);
      periph_req <= 18'h0;
   endtask

   // ==========================================================
   // hang guard
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      end_of_test();
   end

   // ==========================================================
   // main sequence
   initial begin
      seed = 18;
      failures = 0;
      checked = 0;
      sys_rst = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {accept_valid, accept_source, accept_swi, periph_req, bkpt_table} = '0;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      // reset values, then an unmapped place
      reg_read(`REG_VBP, 32'h0);
      reg_read(`REG_CTRL, 32'h0);
      reg_read(`REG_REQ, 32'h0);
      reg_read(8'hFC, 32'h0);
      // random even base, as software is advised to load
      base = 24'($random(seed)) & 24'hFFFFFE;
      emu = 24'($random(seed));
      reg_write(`REG_VBP, {8'h00, base});
      reg_read(`REG_VBP, {8'h00, base});
      // debugger owns the emulator vector; only it writes here
      reg_write(`REG_EMU, {8'h00, emu});
      reg_write(`REG_CTRL, 32'h2);
      for (int i = 0; i < 7; i++) begin
         take(4'(i), 6'h0, vec_of(fixed_vec[i]), 8);
      end
      bkpt_table = 1'b1;
      take(SRC_BKPT, 6'h0, vec_of(base), 15);
      bkpt_table = 1'b0;
      // enable flag is clear: debugger sources must still get through
      take(SRC_DBGBRK, 6'h0, emu, 1);
      take(SRC_SSTEP, 6'h0, emu, 1);
      reg_write(`REG_CTRL, 32'h0);
      take(SRC_AMATCH, 6'h0, 24'h0, 0);
      for (int i = 0; i < 16; i++) begin
         swi = (i < 8) ? 6'(i) : 6'($random(seed));
         take(SRC_SWINT, swi, vec_of(base + {16'h0, swi, 2'b00}), 8);
      end
      // every peripheral slot, processor level 2, levels 3 to 7
      for (int k = 0; k < 18; k++) begin
         reg_write(8'(`REG_LVL0 + 4 * k), 32'(3 + k % 5));
      end
      reg_write(`REG_CTRL, 32'h21);
      for (int k = 0; k < 18; k++) begin
         pulse(18'h1 << k);
         serve(k);
         reg_read(`REG_REQ, 32'h0);
      end
      // masked by the flag, then a level equal to ipl stays pending
      reg_write(`REG_LVL0 + 8'h14, 32'h2);
      reg_write(`REG_CTRL, 32'h20);
      pulse(18'h2A);
      wait_vec(20, n);
      check_val("latency", 32'h0, 32'(n));
      reg_read(`REG_REQ, 32'h2A);
      reg_write(`REG_CTRL, 32'h21);
      // the maskable fetch has begun, so offers are refused meanwhile
      repeat (2) @(negedge clock);
      check_val("accept ready", 32'h0, {31'h0, accept_ready});
      serve(1);
      serve(3);
      wait_vec(20, n);
      check_val("latency", 32'h0, 32'(n));
      reg_read(`REG_REQ, 32'h20);
      // software clears with zero and cannot set with one
      reg_write(`REG_REQ, 32'h0);
      reg_read(`REG_REQ, 32'h0);
      reg_write(`REG_REQ, 32'hFFFFFFFF);
      reg_read(`REG_REQ, 32'h0);
      end_of_test();
   end
endmodule

// >>> dv/vector_memory_model.sv
// behavioural vector memory answering the byte fetches of the lookup block
`timescale 1ns/1ps
module vector_memory_model (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        bkpt_table,
   input  wire logic        mem_rd,
   input  wire logic [23:0] mem_addr,
   output logic      [7:0]  mem_rdata
);
   // ==========================================================
   // memory contents
   // each byte is derived from its own address, so a wrong byte order shows up
   function automatic logic [7:0] content(input logic [23:0] a);
      if (bkpt_table && a == 24'hFFFFE7) begin
         content = 8'hFF;
      end else begin
         content = a[7:0] ^ a[15:8] ^ 8'hA5;
      end
   endfunction

   // ==========================================================
   // read port
   // outside a read the line toggles, so a stale byte never passes as valid data
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mem_rdata <= 8'h00;
      end else if (mem_rd) begin
         mem_rdata <= content(mem_addr);
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// >>> verilog/fetch_if.sv
// request and answer between the lookup control and the byte fetcher
`timescale 1ns/1ps
interface fetch_if;
   logic        go;
   logic [23:0] base;
   logic        done;
   logic [31:0] word;

   modport ctrl   (output go, base, input done, word);
   modport engine (input go, base, output done, word);
endinterface

// >>> verilog/interrupt_vector_address_lookup.sv
// interrupt vector address lookup: slot selection, vector fetch, request bits
// Contract
// R1: an accepted interrupt yields the start address stored in its vector slot.
// R2: fixed four-byte slots sit at unchangeable addresses from FFFFDC upward.
// R3: undefined opcode trap fetches its vector from FFFFDC to FFFFDF.
// R4: overflow trap fetches its vector from FFFFE0 to FFFFE3.
// R5: breakpoint uses FFFFE4; top byte FF redirects to the relocatable table.
// R6: address match, gated by its enable bit, uses slot FFFFE8.
// R7: watchdog, nmi pin and reset use slots FFFFF0, FFFFF8, FFFFFC.
// R8: debugger break and single step use the emulator vector, never masked.
// R9: software must leave the emulator vector register to the debugger.
// R10: relocatable slot n sits at vector base pointer plus four times n.
// R11: software should load an even vector base pointer.
// R12: number 0 is the breakpoint slot at base +0, not maskable.
// R13: transfer channels 0 to 3 use numbers 8 to 11 from +32.
// R14: group-A timers 0 to 4 use numbers 12 to 16 from +48.
// R15: serial 0 tx, 0 rx, 1 tx, 1 rx use numbers 17 to 20.
// R16: group-B timers 0 to 4 use numbers 21 to 25 from +84.
// R17: maskable ack needs enable flag, request bit and level above processor level.
// R18: hardware clears a request bit at jump; software clears, never sets.
// R19: four bytes read low address first, assembled into the start address.
// R20: unassigned numbers 1 to 7 still map to base plus four times n.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "ivl_cfg.svh"
module interrupt_vector_address_lookup
   import ivl_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire logic [7:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [31:0]                 reg_rdata,
   input  wire logic                   accept_valid,
   input  wire logic [3:0]             accept_source,
   input  wire logic [5:0]             accept_swi,
   output logic                        accept_ready,
   input  wire logic [`NUM_PERIPH-1:0] periph_req,
   output logic                        mem_rd,
   output logic [23:0]                 mem_addr,
   input  wire logic [7:0]             mem_rdata,
   output logic                        vec_valid,
   output logic [23:0]                 vec_addr,
   output logic [5:0]                  vec_swi
);

   main_state_t             state_ff;
   logic [23:0]             vbp_ff;
   logic [23:0]             emu_ff;
   logic                    iflag_ff;
   logic                    amen_ff;
   logic [2:0]              plvl_ff;
   logic [`NUM_PERIPH-1:0]  req_ff;
   logic [2:0]              lvl_ff [`NUM_PERIPH];
   logic [`NUM_PERIPH-1:0]  elig;
   logic                    any_elig;
   logic [4:0]              pick;
   logic [4:0]              pick_ff;
   logic                    mask_ff;
   logic                    bkpt_chk_ff;
   logic                    go_ff;
   logic [23:0]             slot_ff;
   logic [23:0]             fix_slot;
   logic                    fix_src;
   logic                    emu_src;
   logic                    fire;
   logic                    redo;
   logic                    hw_clear;
   logic [5:0]              pick_swi;
   logic                    vec_valid_ff;
   logic [23:0]             vec_addr_ff;
   logic [5:0]              vec_swi_ff;
   logic [31:0]             nxt_rdata;
   logic [31:0]             rdata_ff;
   src_t                    src;

   fetch_if fb ();

   assign src = src_t'(accept_source);

   // ==========================================================
   // byte fetcher
   vector_byte_fetch u_fetch (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .fb        (fb.engine),
      .mem_rd    (mem_rd),
      .mem_addr  (mem_addr),
      .mem_rdata (mem_rdata)
   );

   assign fb.go   = go_ff;
   assign fb.base = slot_ff;

   // ==========================================================
   // software-visible registers
   // software owns the base pointer; an odd value works and the fetch takes no longer
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         vbp_ff   <= `RST_VBP;
         emu_ff   <= `RST_EMU;
         iflag_ff <= 1'b0;
         amen_ff  <= 1'b0;
         plvl_ff  <= `RST_PLVL;
      end else if (reg_wr) begin
         if (reg_addr == `REG_VBP) vbp_ff <= reg_wdata[23:0];
         // debugger-only location; software stays away from it [R9]
         if (reg_addr == `REG_EMU) emu_ff <= reg_wdata[23:0];
         if (reg_addr == `REG_CTRL) begin
            iflag_ff <= reg_wdata[`CTRL_IFLAG];
            amen_ff  <= reg_wdata[`CTRL_AMEN];
            plvl_ff  <= reg_wdata[`CTRL_PLVL_HI:`CTRL_PLVL_LO];
         end
      end
   end

   // ==========================================================
   // per-source request bits and priority levels
   // a peripheral event beats any clear in the same cycle, so none is lost
   generate
      for (genvar k = 0; k < `NUM_PERIPH; k++) begin : g_src
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               req_ff[k] <= 1'b0;
            end else if (periph_req[k]) begin
               req_ff[k] <= 1'b1;
            end else if (hw_clear && pick_ff == 5'(k)) begin
               req_ff[k] <= 1'b0;  // cleared on the vector jump [R18]
            end else if (reg_wr && reg_addr == `REG_REQ && !reg_wdata[k]) begin
               req_ff[k] <= 1'b0;  // software writes 0 to clear, 1 is ignored [R18]
            end
         end

         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               lvl_ff[k] <= `RST_LVL;
            end else if (reg_wr && reg_addr == `REG_LVL0 + 8'(4 * k)) begin
               lvl_ff[k] <= reg_wdata[2:0];
            end
         end

         // level strictly above the processor level, flag set, bit pending
         assign elig[k] = req_ff[k] && iflag_ff && (lvl_ff[k] > plvl_ff);  // [R17]
      end
   endgenerate

   // lowest-numbered eligible source wins; finer arbitration lives elsewhere
   always_comb begin
      pick = 5'h00;
      for (int i = `NUM_PERIPH - 1; i >= 0; i--) begin
         if (elig[i]) pick = 5'(i);
      end
   end

   assign any_elig = |elig;
   // peripheral k maps to number 8 + k: channels, timers A, serial, timers B
   assign pick_swi = `SWI_PERIPH0 + {1'b0, pick};  // [R13] [R14] [R15] [R16]

   // ==========================================================
   // fixed slot decode for sources that do not use the table
   always_comb begin
      fix_slot = `VEC_UNDEF;
      fix_src  = 1'b1;
      unique case (src)
         SRC_UNDEF:  fix_slot = `VEC_UNDEF;   // [R2] [R3]
         SRC_OVF:    fix_slot = `VEC_OVF;     // [R4]
         SRC_BKPT:   fix_slot = `VEC_BKPT;    // [R5]
         SRC_AMATCH: fix_slot = `VEC_AMATCH;  // [R6]
         SRC_WDT:    fix_slot = `VEC_WDT;     // [R7]
         SRC_NMI:    fix_slot = `VEC_NMI;     // [R7]
         SRC_RST:    fix_slot = `VEC_RST;     // [R7]
         default:    fix_src  = 1'b0;
      endcase
   end

   // debugger sources bypass the enable flag and memory entirely
   assign emu_src      = (src == SRC_DBGBRK) || (src == SRC_SSTEP);  // [R8]
   assign accept_ready = (state_ff == ST_IDLE);
   assign fire         = accept_valid && accept_ready;
   assign redo         = bkpt_chk_ff && (fb.word[31:24] == `BKPT_TBL_FLAG);  // [R5]
   assign hw_clear     = (state_ff == ST_FETCH) && fb.done && mask_ff;

   // ==========================================================
   // control state: accept, start fetch, redirect breakpoint, finish
   // the sequencer's nonmaskable request beats a pending maskable one
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff   <= ST_IDLE;
         go_ff      <= 1'b0;
         slot_ff    <= 24'h000000;
         bkpt_chk_ff <= 1'b0;
         mask_ff    <= 1'b0;
         pick_ff    <= 5'h00;
      end else begin
         go_ff <= 1'b0;
         unique case (state_ff)
            ST_IDLE: begin
               if (fire) begin
                  mask_ff    <= 1'b0;
                  bkpt_chk_ff <= (src == SRC_BKPT);
                  if (emu_src) begin
                     state_ff <= ST_IDLE;
                  end else if (src == SRC_AMATCH && !amen_ff) begin
                     state_ff <= ST_IDLE;  // disabled match is dropped [R6]
                  end else if (fix_src) begin
                     state_ff <= ST_FETCH;
                     go_ff    <= 1'b1;
                     slot_ff  <= fix_slot;
                  end else begin
                     state_ff <= ST_FETCH;
                     go_ff    <= 1'b1;
                     // any number 0..63, assigned or not [R10] [R12] [R20]
                     slot_ff  <= vbp_ff + {16'h0000, accept_swi, 2'b00};
                  end
               end else if (any_elig) begin
                  state_ff   <= ST_FETCH;
                  go_ff      <= 1'b1;
                  mask_ff    <= 1'b1;
                  bkpt_chk_ff <= 1'b0;
                  pick_ff    <= pick;
                  slot_ff    <= vbp_ff + {16'h0000, pick_swi, 2'b00};  // [R10] [R17]
               end
            end
            ST_FETCH: begin
               if (fb.done && redo) begin
                  go_ff      <= 1'b1;
                  bkpt_chk_ff <= 1'b0;
                  slot_ff    <= vbp_ff + {16'h0000, `SWI_BKPT, 2'b00};  // [R5] [R12]
               end else if (fb.done) begin
                  state_ff <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // vector answer to the sequencer, one-cycle pulse
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         vec_valid_ff <= 1'b0;
         vec_addr_ff  <= 24'h000000;
         vec_swi_ff   <= 6'h00;
      end else begin
         vec_valid_ff <= 1'b0;
         if (state_ff == ST_IDLE && fire && emu_src) begin
            vec_valid_ff <= 1'b1;
            vec_addr_ff  <= emu_ff;  // [R8]
            vec_swi_ff   <= 6'h00;
         end else if (state_ff == ST_FETCH && fb.done && !redo) begin
            vec_valid_ff <= 1'b1;
            vec_addr_ff  <= fb.word[23:0];  // [R1] [R19]
            vec_swi_ff   <= mask_ff ? `SWI_PERIPH0 + {1'b0, pick_ff} : 6'h00;
         end
      end
   end

   assign vec_valid = vec_valid_ff;
   assign vec_addr  = vec_addr_ff;
   assign vec_swi   = vec_swi_ff;

   // ==========================================================
   // register read path, data one cycle after the strobe
   always_comb begin
      nxt_rdata = 32'h00000000;
      if (reg_addr == `REG_VBP)  nxt_rdata = {8'h00, vbp_ff};
      if (reg_addr == `REG_EMU)  nxt_rdata = {8'h00, emu_ff};
      if (reg_addr == `REG_CTRL) begin
         nxt_rdata[`CTRL_IFLAG]                 = iflag_ff;
         nxt_rdata[`CTRL_AMEN]                  = amen_ff;
         nxt_rdata[`CTRL_PLVL_HI:`CTRL_PLVL_LO] = plvl_ff;
      end
      if (reg_addr == `REG_REQ)  nxt_rdata = {14'h0000, req_ff};
      if (reg_addr == `REG_STAT) nxt_rdata = {26'h0000000, mask_ff, pick_ff == 5'h00,
                                              bkpt_chk_ff, any_elig, state_ff};
      for (int i = 0; i < `NUM_PERIPH; i++) begin
         if (reg_addr == `REG_LVL0 + 8'(4 * i)) nxt_rdata = {29'h00000000, lvl_ff[i]};
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) rdata_ff <= 32'h00000000;
      else         rdata_ff <= reg_rd ? nxt_rdata : 32'h00000000;
   end

   assign reg_rdata = rdata_ff;

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence fetch_end_s;
      state_ff == ST_FETCH && fb.done;
   endsequence

   sequence bkpt_flag_seen_s;
      fetch_end_s ##0 bkpt_chk_ff && fb.word[31:24] == `BKPT_TBL_FLAG;
   endsequence

   chk_undef_slot: assert property (  // [R3]
      fire && src == SRC_UNDEF |=> go_ff && slot_ff == `VEC_UNDEF)
      else $error("undefined opcode slot wrong");

   chk_ovf_slot: assert property (  // [R4]
      fire && src == SRC_OVF |-> ##1 go_ff ##0 slot_ff == `VEC_OVF)
      else $error("overflow slot wrong");

   chk_bkpt_redirect: assert property (  // [R5]
      bkpt_flag_seen_s |=> go_ff && slot_ff == $past(vbp_ff) && !vec_valid_ff)
      else $error("breakpoint flag did not redirect to table");

   chk_amatch_gate: assert property (  // [R6]
      fire && src == SRC_AMATCH |=> go_ff == $past(amen_ff))
      else $error("address match enable not honoured");

   chk_nmi_slot: assert property (  // [R7]
      fire && src == SRC_NMI |=> slot_ff == `VEC_NMI ##7 vec_valid_ff)
      else $error("nmi slot or timing wrong");

   chk_emu_vector: assert property (  // [R8]
      fire && emu_src |=> vec_valid_ff && vec_addr_ff == $past(emu_ff))
      else $error("emulator vector not delivered");

   chk_table_slot: assert property (  // [R10]
      fire && src == SRC_SWINT
      |=> slot_ff == $past(vbp_ff) + {16'h0000, $past(accept_swi), 2'b00})
      else $error("table slot address wrong");

   chk_mask_gate: assert property (  // [R17]
      state_ff == ST_IDLE && !fire && any_elig |=> mask_ff && $past(iflag_ff) ##0
      $past(lvl_ff[pick]) > $past(plvl_ff))
      else $error("maskable request taken while not eligible");

   chk_req_clear: assert property (  // [R18]
      fetch_end_s ##0 mask_ff && !redo && !periph_req[pick_ff]
      |=> !req_ff[$past(pick_ff)] && vec_valid_ff)
      else $error("request bit not cleared on jump");

   chk_vector_value: assert property (  // [R1]
      fetch_end_s ##0 !redo |=> vec_addr_ff == $past(fb.word[23:0]))
      else $error("vector differs from fetched bytes");

endmodule

// >>> verilog/ivl_cfg.svh
// constants for the interrupt vector address lookup block
`ifndef IVL_CFG_SVH
`define IVL_CFG_SVH

// ==========================================================
// fixed vector slots, four bytes each, low byte first
`define VEC_UNDEF      24'hFFFFDC
`define VEC_OVF        24'hFFFFE0
`define VEC_BKPT       24'hFFFFE4
`define VEC_AMATCH     24'hFFFFE8
`define VEC_WDT        24'hFFFFF0
`define VEC_NMI        24'hFFFFF8
`define VEC_RST        24'hFFFFFC
`define BKPT_TBL_FLAG  8'hFF
`define VEC_LAST_BYTE  2'h3

// ==========================================================
// relocatable table numbering
`define SWI_BKPT       6'h00
`define SWI_PERIPH0    6'h08
`define NUM_PERIPH     18

// ==========================================================
// register offsets (byte addresses on the register port)
`define REG_VBP        8'h00
`define REG_EMU        8'h04
`define REG_CTRL       8'h08
`define REG_REQ        8'h0C
`define REG_STAT       8'h10
`define REG_LVL0       8'h20

// ==========================================================
// control fields and reset values
`define CTRL_IFLAG     0
`define CTRL_AMEN      1
`define CTRL_PLVL_LO   4
`define CTRL_PLVL_HI   6
`define RST_VBP        24'h000000
`define RST_EMU        24'h000000
`define RST_PLVL       3'h0
`define RST_LVL        3'h0

`endif

// >>> verilog/ivl_pkg.sv
// types shared by the vector lookup modules
package ivl_pkg;

   // source of an interrupt accepted by the sequencer
   typedef enum logic [3:0] {
      SRC_UNDEF  = 4'h0,
      SRC_OVF    = 4'h1,
      SRC_BKPT   = 4'h2,
      SRC_AMATCH = 4'h3,
      SRC_WDT    = 4'h4,
      SRC_NMI    = 4'h5,
      SRC_RST    = 4'h6,
      SRC_DBGBRK = 4'h7,
      SRC_SSTEP  = 4'h8,
      SRC_SWINT  = 4'h9
   } src_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_FETCH = 2'b10
   } main_state_t;

   typedef enum logic [3:0] {
      F_IDLE = 4'b0001,
      F_READ = 4'b0010,
      F_WAIT = 4'b0100,
      F_DONE = 4'b1000
   } fetch_state_t;

endpackage

// >>> verilog/vector_byte_fetch.sv
// reads four vector bytes from memory and assembles the start address
`timescale 1ns/1ps
`include "ivl_cfg.svh"
module vector_byte_fetch
   import ivl_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        sys_rst,
   fetch_if.engine          fb,
   output logic             mem_rd,
   output logic [23:0]      mem_addr,
   input  wire logic [7:0]  mem_rdata
);

   fetch_state_t state_ff;
   logic [1:0]   cnt_ff;
   logic         rd_q_ff;
   logic [1:0]   idx_q_ff;
   logic [31:0]  word_ff;

   // ==========================================================
   // sequencing: four back-to-back byte reads, one wait cycle, then one answer cycle
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= F_IDLE;
         cnt_ff   <= 2'h0;
         mem_addr <= 24'h000000;
      end else begin
         unique case (state_ff)
            F_IDLE: begin
               if (fb.go) begin
                  state_ff <= F_READ;
                  cnt_ff   <= 2'h0;
                  mem_addr <= fb.base;
               end
            end
            F_READ: begin
               cnt_ff   <= cnt_ff + 2'h1;
               mem_addr <= mem_addr + 24'h000001;  // consecutive bytes [R19]
               if (cnt_ff == `VEC_LAST_BYTE) state_ff <= F_WAIT;
            end
            F_WAIT: state_ff <= F_DONE;
            F_DONE: state_ff <= F_IDLE;
         endcase
      end
   end

   // ==========================================================
   // read data returns one cycle after the strobe; lowest address is low byte
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rd_q_ff  <= 1'b0;
         idx_q_ff <= 2'h0;
         word_ff  <= 32'h00000000;
      end else begin
         rd_q_ff  <= mem_rd;
         idx_q_ff <= cnt_ff;
         if (rd_q_ff) word_ff[{idx_q_ff, 3'h0} +: 8] <= mem_rdata;  // [R19]
      end
   end

   assign mem_rd  = (state_ff == F_READ);
   assign fb.done = (state_ff == F_DONE);
   assign fb.word = word_ff;

   chk_byte_order: assert property (  // [R19]
      @(posedge clock) disable iff (sys_rst)
      mem_rd && cnt_ff != 2'h0 |-> mem_addr == $past(mem_addr) + 24'h000001)
      else $error("vector bytes not read at consecutive addresses");

endmodule
